// ==== shared/mfd_pkg.sv ====
package mfd_pkg;
  // Holding register addresses
  localparam logic [15:0] HR_FAULT_CLEAR = 16'h0000;
  localparam logic [15:0] HR_SPEED_FLOOR = 16'h0001;
  localparam logic [15:0] HR_SPEED_CEIL = 16'h0002;
  localparam logic [15:0] HR_CURR_LIMIT = 16'h0007;
  localparam logic [15:0] HR_FIXED_SPEED = 16'h0015;
  localparam logic [15:0] HR_REG_POLARITY = 16'h001f;
  localparam logic [15:0] HR_SKIP_LOW = 16'h0020;
  localparam logic [15:0] HR_SKIP_HIGH = 16'h0021;
  localparam logic [15:0] HR_MODE_SELECT = 16'h0022;
  localparam logic [15:0] HR_POWER_LIMIT = 16'h0024;
  localparam logic [15:0] HR_STATION_ADDR = 16'h002d;
  localparam logic [15:0] HR_DOUT_FUNC = 16'h002e;
  localparam logic [15:0] HR_LINE_RATE = 16'h002f;
  localparam logic [15:0] HR_FRAMING = 16'h0030;
  localparam logic [15:0] HR_REG_REF = 16'h0032;
  localparam logic [15:0] HR_REG_KP = 16'h0033;
  localparam logic [15:0] HR_REG_KI = 16'h0034;
  localparam logic [15:0] HR_REG_KD = 16'h0035;
  localparam logic [15:0] HR_REG_PERIOD = 16'h0036;
  localparam logic [15:0] HR_SPEED_ALARM = 16'h0037;
  localparam logic [15:0] HR_LINK_TIMEOUT = 16'h0038;
  localparam logic [15:0] HR_VOLATILE_SP = 16'h0042;
  localparam int HR_DEPTH = 64;
  // Input register addresses
  localparam logic [15:0] IR_TEMPERATURE = 16'h000f;
  localparam logic [15:0] IR_ALARM = 16'h0011;
  localparam logic [15:0] ALARM_LINK_LOST = 16'h00ff;
  // Function codes and exceptions
  localparam logic [7:0] FC_READ_HOLD = 8'h03;
  localparam logic [7:0] FC_READ_INPUT = 8'h04;
  localparam logic [7:0] FC_WRITE_SINGLE = 8'h06;
  localparam logic [7:0] EXC_ILLEGAL_FUNC = 8'h01;
  localparam logic [7:0] EXC_ILLEGAL_ADDR = 8'h02;
  localparam logic [7:0] EXC_ILLEGAL_VALUE = 8'h03;
  localparam logic [7:0] BROADCAST_ADDR = 8'h00;
  // Limits and reset values
  localparam logic [15:0] ADDR_MAX = 16'h00f7;
  localparam logic [15:0] MODE_MAX = 16'h000c;
  localparam logic [15:0] MODE_RESET = 16'h0001;
  localparam logic [15:0] MODE_FOLLOW = 16'h0003;
  localparam logic [15:0] FRAMING_MAX = 16'h0002;
  localparam logic [15:0] TIMEOUT_MAX = 16'h7fff;
  localparam logic [15:0] POWER_MIN = 16'h000a;
  localparam logic [15:0] SKIP_RESET = 16'h4e20;
  localparam logic [15:0] ADDR_RESET = 16'h0001;
  localparam logic [15:0] DOUT_TACHO = 16'h0000;
  localparam logic [15:0] TEMP_CLEAR = 16'h004b;
  // Line rate codes: 0=9600 1=19200 2=38400 3=57600
  localparam logic [1:0] RATE_9600 = 2'd0;
  localparam logic [1:0] RATE_57600 = 2'd3;
  localparam logic [1:0] RATE_RS485_MAX = 2'd1;
  // Timing
  localparam int CLK_HZ = 25000000;
  localparam int SECOND_CYCLES = CLK_HZ;
  // Bus operation codes
  typedef enum logic [1:0] {
    MFD_OP_IDLE = 2'b00,
    MFD_OP_READ = 2'b01,
    MFD_OP_WRITE = 2'b10
  } mfd_op_e;
endpackage

// ==== shared/mfd_mem_if.sv ====
interface mfd_mem_if;
  logic we;
  logic [5:0] waddr;
  logic [15:0] wdata;
  logic [5:0] raddr;
  logic [15:0] rdata;
  modport ctrl (output we, output waddr, output wdata, output raddr,
                input rdata);
  modport mem (input we, input waddr, input wdata, input raddr,
               output rdata);
endinterface

// ==== hw/mfd_hold_mem.sv ====
module mfd_hold_mem #(
  parameter int DEPTH = 64
) (
  input wire logic CLK,
  mfd_mem_if.mem port
);
  logic [15:0] store [DEPTH];

  // Registered read, single write port
  always_ff @(posedge CLK) begin
    if (port.we) begin
      store[port.waddr] <= port.wdata;
    end
    port.rdata <= store[port.raddr];
  end
endmodule

// ==== hw/mfd_regif.sv ====
// How it works
// RULE1: Out-of-bounds writes leave the stored value untouched, never clamped.
// RULE2: Line rate register selects speed; RS-485 allows 9600 and 19200 only.
// RULE3: Service serial link also allows 38400 and 57600.
// RULE4: Framing 0 none/2 stop, 1 odd/1 stop, 2 even/1 stop.
// RULE5: Functions 03, 04 and 06 are supported.
// RULE6: Timeout 0 disables; 1..32767 sets silence in seconds, then stop.
// RULE7: Timeout expiry sets alarm input register to 255.
// RULE8: Master resumes traffic then clears alarm before fan runs.
// RULE9: Station address accepts 1..247, resets to 1.
// RULE10: Station address zero is accepted as broadcast.
// RULE11: Defaults 9600, framing 0, address 1; 3-phase service link 57600.
// RULE12: Rate acts at once; address and framing only after restart.
// RULE13: Volatile setpoint is write-only, reads return zero.
// RULE14: Writing 1 to reset register clears faults, restarts, self-clears.
// RULE15: Persistent array of 64 entries, 26 user-writable; the code accepts writes at 22 addresses.
// RULE16: Overtemperature limits current and alarms; clears below 75 C.
// RULE17: Drive temperature readable in an input register.
// RULE18: Thermal protector trip stops fan and flags error.
// RULE19: High switching frequency at low speed, low at high speed.
// RULE20: Digital output function 0 delivers the tacho signal.
// RULE21: Follower on small single-phase units uses mode 3.
// RULE22: Master writes holding registers only while fan stopped.
// RULE23: Mode select accepts 0..12, default 1.
// RULE24: Unsupported function gets exception; broadcasts never answered.
// RULE25: Bad CRC or foreign address frames are discarded silently.
module mfd_regif #(
  parameter logic THREE_PHASE = 1'b0,
  parameter logic VAR_SWITCH = 1'b0,
  parameter logic [15:0] SWITCH_SPEED = 16'h03e8,
  parameter logic [15:0] TEMP_LIMIT = 16'h0055,
  parameter int SECOND = mfd_pkg::SECOND_CYCLES
) (
  input wire logic CLK,
  input wire logic SRST,
  input wire logic SERVICE_LINK,
  input wire logic REQ_VALID,
  input wire logic REQ_CRC_OK,
  input wire logic [7:0] REQ_STATION,
  input wire logic [7:0] REQ_FUNC,
  input wire logic [15:0] REQ_ADDR,
  input wire logic [15:0] REQ_DATA,
  input wire logic [15:0] TEMPERATURE,
  input wire logic PROTECTOR_OPEN,
  input wire logic TACHO_IN,
  input wire logic [15:0] SPEED_NOW,
  output logic RSP_VALID,
  output logic RSP_EXCEPTION,
  output logic [7:0] RSP_FUNC,
  output logic [15:0] RSP_DATA,
  output logic [1:0] LINE_RATE,
  output logic [1:0] LINE_FRAMING,
  output logic [7:0] ACTIVE_STATION,
  output logic [15:0] VOLATILE_SETPOINT,
  output logic [15:0] CURRENT_LIMIT,
  output logic [3:0] OP_MODE,
  output logic RUN_ENABLE,
  output logic DERATE,
  output logic SWITCH_HIGH,
  output logic DIGITAL_OUT,
  output logic RESTART
);
  import mfd_pkg::*;

  // Persistent holding array, registered read
  mfd_mem_if mem_bus ();
  mfd_hold_mem #(.DEPTH(HR_DEPTH)) u_mem (.CLK(CLK), .port(mem_bus.mem));

  // Shadow copies of holding registers steering logic
  logic [15:0] floor_r, ceil_r, curr_r, mode_r, addr_r, dout_r;
  logic [15:0] rate_r, frame_r, timeout_r, skip_lo, skip_hi, power_r;
  logic [15:0] curr_max, power_max;
  logic [7:0] boot_station;
  logic [1:0] boot_framing;
  logic link_alarm, derate_alarm, prot_alarm;
  logic [31:0] tick;
  logic [15:0] secs;
  logic pend_read;
  logic [7:0] pend_func;
  logic [15:0] pend_addr;

  // Request qualification
  // RULE10 broadcast station zero
  wire is_bcast = REQ_STATION == BROADCAST_ADDR;
  wire is_mine = REQ_STATION == boot_station;
  // RULE25 drop bad frames
  wire accepted = REQ_VALID && REQ_CRC_OK && (is_mine || is_bcast);
  // RULE5 supported functions
  wire fc_rd_h = REQ_FUNC == FC_READ_HOLD;
  wire fc_rd_i = REQ_FUNC == FC_READ_INPUT;
  wire fc_wr = REQ_FUNC == FC_WRITE_SINGLE;
  wire fc_ok = fc_rd_h || fc_rd_i || fc_wr;
  wire do_write = accepted && fc_wr;
  wire [15:0] d = REQ_DATA;

  // RULE15 user-writable set
  wire addr_user = (REQ_ADDR == HR_FAULT_CLEAR) ||
    (REQ_ADDR == HR_SPEED_FLOOR) || (REQ_ADDR == HR_SPEED_CEIL) ||
    (REQ_ADDR == HR_CURR_LIMIT) || (REQ_ADDR == HR_FIXED_SPEED) ||
    (REQ_ADDR == HR_REG_POLARITY) || (REQ_ADDR == HR_SKIP_LOW) ||
    (REQ_ADDR == HR_SKIP_HIGH) || (REQ_ADDR == HR_MODE_SELECT) ||
    (REQ_ADDR == HR_POWER_LIMIT) || (REQ_ADDR == HR_STATION_ADDR) ||
    (REQ_ADDR == HR_DOUT_FUNC) || (REQ_ADDR == HR_LINE_RATE) ||
    (REQ_ADDR == HR_FRAMING) || (REQ_ADDR == HR_VOLATILE_SP) ||
    ((REQ_ADDR >= HR_REG_REF) && (REQ_ADDR <= HR_LINK_TIMEOUT));

  // RULE2 rate bound per link
  wire [15:0] rate_max = SERVICE_LINK ? 16'h0003 : 16'h0001;
  // Value bounds per register
  logic in_bounds;
  always_comb begin
    in_bounds = 1'b1;
    unique case (REQ_ADDR)
      HR_FAULT_CLEAR: in_bounds = d <= 16'h0001;
      HR_SPEED_FLOOR: in_bounds = d <= ceil_r;
      HR_SPEED_CEIL: in_bounds = d >= floor_r;
      HR_CURR_LIMIT: in_bounds = d >= 16'h0001 && d <= curr_max;
      HR_FIXED_SPEED: in_bounds = d >= floor_r && d <= ceil_r;
      HR_REG_POLARITY: in_bounds = d <= 16'h0001;
      HR_SKIP_LOW: in_bounds = d <= skip_hi;
      HR_SKIP_HIGH: in_bounds = d >= skip_lo;
      // RULE23 mode range
      HR_MODE_SELECT: in_bounds = d <= MODE_MAX;
      HR_POWER_LIMIT: in_bounds = d >= POWER_MIN && d <= power_max;
      // RULE9 address range
      HR_STATION_ADDR: in_bounds = d >= 16'h0001 && d <= ADDR_MAX;
      // RULE3 four rates on service link
      HR_LINE_RATE: in_bounds = d <= rate_max;
      // RULE4 framing codes
      HR_FRAMING: in_bounds = d <= FRAMING_MAX;
      // RULE6 timeout range
      HR_LINK_TIMEOUT: in_bounds = d <= TIMEOUT_MAX;
      default: in_bounds = 1'b1;
    endcase
  end
  // RULE1 reject, no coercion
  wire wr_ok = do_write && addr_user && in_bounds;
  wire wr_sp = wr_ok && REQ_ADDR == HR_VOLATILE_SP;
  // RULE14 reset register write
  wire wr_clear = wr_ok && REQ_ADDR == HR_FAULT_CLEAR && d[0];

  // Persistent array port; volatile setpoint not stored
  assign mem_bus.we = wr_ok && !wr_sp && REQ_ADDR != HR_FAULT_CLEAR;
  assign mem_bus.waddr = REQ_ADDR[5:0];
  assign mem_bus.wdata = d;
  assign mem_bus.raddr = REQ_ADDR[5:0];

  // Shadow register updates
  always_ff @(posedge CLK) begin
    if (SRST) begin
      floor_r <= 16'h0000;
      ceil_r <= 16'hffff;
      curr_max <= 16'hffff;
      curr_r <= 16'hffff;
      power_max <= 16'hffff;
      power_r <= 16'hffff;
      mode_r <= MODE_RESET;
      // RULE12 stored address and framing survive a restart
      // Unknown or illegal contents fall back to the factory value
      if (addr_r >= 16'h0001 && addr_r <= ADDR_MAX) begin
        addr_r <= addr_r;
      end else begin
        addr_r <= ADDR_RESET;
      end
      // RULE11 factory defaults
      rate_r <= {14'h0000, (THREE_PHASE && SERVICE_LINK) ? RATE_57600
                                                         : RATE_9600};
      if (frame_r <= FRAMING_MAX) begin
        frame_r <= frame_r;
      end else begin
        frame_r <= 16'h0000;
      end
      dout_r <= DOUT_TACHO;
      timeout_r <= 16'h0000;
      skip_lo <= SKIP_RESET;
      skip_hi <= SKIP_RESET;
    end else if (mem_bus.we) begin
      unique case (REQ_ADDR)
        HR_SPEED_FLOOR: floor_r <= d;
        HR_SPEED_CEIL: ceil_r <= d;
        HR_CURR_LIMIT: curr_r <= d;
        HR_POWER_LIMIT: power_r <= d;
        HR_MODE_SELECT: mode_r <= d;
        HR_STATION_ADDR: addr_r <= d;
        HR_LINE_RATE: rate_r <= d;
        HR_FRAMING: frame_r <= d;
        HR_DOUT_FUNC: dout_r <= d;
        HR_LINK_TIMEOUT: timeout_r <= d;
        HR_SKIP_LOW: skip_lo <= d;
        HR_SKIP_HIGH: skip_hi <= d;
        default: ;
      endcase
    end
  end

  // RULE12 address/framing latched at restart only
  // Two reset edges are needed at power-up to load defaults
  always_ff @(posedge CLK) begin
    if (SRST) begin
      boot_station <= addr_r[7:0];
      boot_framing <= frame_r[1:0];
    end
  end

  // RULE13 volatile setpoint kept until the next write or reset
  always_ff @(posedge CLK) begin
    if (SRST) begin
      VOLATILE_SETPOINT <= 16'h0000;
    end else if (wr_sp) begin
      VOLATILE_SETPOINT <= d;
    end
  end

  // RULE6 silence counter in seconds
  // Counting stops at expiry so the count never wraps
  wire expire = timeout_r != 16'h0000 && secs >= timeout_r;
  always_ff @(posedge CLK) begin
    if (SRST || accepted || timeout_r == 16'h0000) begin
      tick <= 32'h0;
      secs <= 16'h0000;
    end else if (!expire) begin
      if (tick == 32'(SECOND - 1)) begin
        tick <= 32'h0;
        secs <= secs + 16'h0001;
      end else begin
        tick <= tick + 32'h1;
      end
    end
  end

  // Alarms: set wins over clear
  // Derating has hysteresis between limit and clear level
  wire hot = TEMPERATURE > TEMP_LIMIT;
  wire cool = TEMPERATURE < TEMP_CLEAR;
  always_ff @(posedge CLK) begin
    if (SRST) begin
      link_alarm <= 1'b0;
      derate_alarm <= 1'b0;
      prot_alarm <= 1'b0;
    end else begin
      // RULE7 link alarm, RULE8 held until cleared
      link_alarm <= expire || (link_alarm && !wr_clear);
      // RULE16 derating with auto clear below 75
      derate_alarm <= hot || (derate_alarm && !cool);
      // RULE18 protector trip latched
      prot_alarm <= PROTECTOR_OPEN || (prot_alarm && !wr_clear);
    end
  end

  // Response path, one cycle after request for memory read
  // Alarm word: ff on link loss, else fault bits
  wire [15:0] alarm_word = link_alarm ? ALARM_LINK_LOST :
    {13'h0000, prot_alarm, derate_alarm, 1'b0};
  always_ff @(posedge CLK) begin
    if (SRST) begin
      pend_read <= 1'b0;
      pend_func <= 8'h00;
      pend_addr <= 16'h0000;
    end else begin
      // RULE24 broadcasts never answered
      pend_read <= accepted && !is_bcast;
      pend_func <= REQ_FUNC;
      pend_addr <= REQ_ADDR;
    end
  end
  // Decode of the request awaiting its answer
  wire p_rd_h = pend_func == FC_READ_HOLD;
  wire p_rd_i = pend_func == FC_READ_INPUT;
  wire p_wr = pend_func == FC_WRITE_SINGLE;
  wire p_fc_ok = p_rd_h || p_rd_i || p_wr;
  wire p_hold_ok = pend_addr < 16'(HR_DEPTH) &&
    pend_addr != HR_FAULT_CLEAR;
  // Write verdict kept for the echo cycle
  logic pend_wr_ok;
  always_ff @(posedge CLK) begin
    if (SRST) begin
      pend_wr_ok <= 1'b0;
    end else begin
      pend_wr_ok <= wr_ok;
    end
  end
  // RULE17 temperature input register
  wire [15:0] input_word = pend_addr == IR_TEMPERATURE ? TEMPERATURE :
    pend_addr == IR_ALARM ? alarm_word : 16'h0000;
  // RULE13 volatile setpoint reads as zero
  wire [15:0] hold_word = pend_addr == HR_VOLATILE_SP ||
    pend_addr == HR_FAULT_CLEAR ? 16'h0000 : mem_bus.rdata;
  // Exception choice and answer word
  wire p_exc = !p_fc_ok || (p_wr && !pend_wr_ok);
  wire [7:0] exc_code = !p_fc_ok ? EXC_ILLEGAL_FUNC : EXC_ILLEGAL_VALUE;
  wire [15:0] rsp_word = p_exc ? {8'h00, exc_code} :
    p_rd_i ? input_word : p_wr ? pend_addr :
    (p_hold_ok || pend_addr == HR_FAULT_CLEAR) ? hold_word : 16'h0000;

  // Outputs from flip-flops
  always_ff @(posedge CLK) begin
    if (SRST) begin
      RSP_VALID <= 1'b0;
      RSP_EXCEPTION <= 1'b0;
      RSP_FUNC <= 8'h00;
      RSP_DATA <= 16'h0000;
      RESTART <= 1'b0;
      RUN_ENABLE <= 1'b0;
    end else begin
      RSP_VALID <= pend_read;
      RSP_EXCEPTION <= pend_read && p_exc;
      RSP_FUNC <= p_exc ? (pend_func | 8'h80) : pend_func;
      RSP_DATA <= rsp_word;
      // RULE14 one-cycle restart, register reads 0
      RESTART <= wr_clear;
      // RULE18 fan stopped on faults
      RUN_ENABLE <= !(link_alarm || prot_alarm || expire);
    end
  end

  // Steering outputs
  always_ff @(posedge CLK) begin
    if (SRST) begin
      LINE_RATE <= RATE_9600;
      LINE_FRAMING <= 2'b00;
      ACTIVE_STATION <= 8'h00;
      CURRENT_LIMIT <= 16'hffff;
      OP_MODE <= 4'h1;
      DERATE <= 1'b0;
      SWITCH_HIGH <= 1'b1;
      DIGITAL_OUT <= 1'b0;
    end else begin
      // RULE2 rate applies at once
      LINE_RATE <= rate_r[1:0];
      LINE_FRAMING <= boot_framing;
      ACTIVE_STATION <= boot_station;
      // RULE16 current limited while derating
      CURRENT_LIMIT <= derate_alarm ? {1'b0, curr_r[15:1]} : curr_r;
      OP_MODE <= mode_r[3:0];
      DERATE <= derate_alarm;
      // RULE19 speed-dependent switching
      SWITCH_HIGH <= !VAR_SWITCH || SPEED_NOW < SWITCH_SPEED;
      // RULE20 tacho on digital output
      DIGITAL_OUT <= dout_r == DOUT_TACHO ? TACHO_IN :
        (link_alarm || prot_alarm || derate_alarm);
    end
  end
endmodule

// ==== sim/mfd_regif_asserts.sv ====
module mfd_regif_asserts
  import mfd_pkg::*;
(
  input wire logic CLK,
  input wire logic SRST,
  input wire logic SERVICE_LINK,
  input wire logic REQ_VALID,
  input wire logic REQ_CRC_OK,
  input wire logic [7:0] REQ_STATION,
  input wire logic [7:0] REQ_FUNC,
  input wire logic [15:0] REQ_ADDR,
  input wire logic [15:0] REQ_DATA,
  input wire logic [15:0] TEMPERATURE,
  input wire logic PROTECTOR_OPEN,
  input wire logic RSP_VALID,
  input wire logic RSP_EXCEPTION,
  input wire logic [7:0] RSP_FUNC,
  input wire logic [15:0] RSP_DATA,
  input wire logic [1:0] LINE_RATE,
  input wire logic [1:0] LINE_FRAMING,
  input wire logic [7:0] ACTIVE_STATION,
  input wire logic RUN_ENABLE,
  input wire logic DERATE,
  input wire logic RESTART
);
  default clocking cb @(posedge CLK); endclocking
  default disable iff (SRST);
  // Request decode as the slave sees it
  wire mine = REQ_VALID && REQ_CRC_OK && REQ_STATION == ACTIVE_STATION;
  wire odd_fc = REQ_FUNC != FC_READ_HOLD && REQ_FUNC != FC_READ_INPUT &&
    REQ_FUNC != FC_WRITE_SINGLE;
  wire clr_wr = mine && REQ_FUNC == FC_WRITE_SINGLE &&
    REQ_ADDR == HR_FAULT_CLEAR && REQ_DATA == 16'h0001;
  a_rsp_latency: assert property (
    mine |-> ##2 RSP_VALID) else $error("response missing");
  a_bcast_silent: assert property (
    REQ_VALID && REQ_STATION == BROADCAST_ADDR |-> ##2 !RSP_VALID)
    else $error("broadcast answered");
  a_foreign_silent: assert property (
    REQ_VALID && (!REQ_CRC_OK || REQ_STATION != ACTIVE_STATION) |->
    ##2 !RSP_VALID) else $error("discarded frame answered");
  a_illegal_func: assert property (
    mine && odd_fc |-> ##2 RSP_EXCEPTION &&
    RSP_DATA == {8'h00, EXC_ILLEGAL_FUNC}) else $error("no func exception");
  a_rsp_func: assert property (
    RSP_VALID |-> RSP_FUNC == ($past(REQ_FUNC, 2) | {RSP_EXCEPTION, 7'h00}))
    else $error("response function wrong");
  a_rs485_rate: assert property (
    !SERVICE_LINK && $changed(LINE_RATE) |-> LINE_RATE <= RATE_RS485_MAX)
    else $error("fast rate on rs485");
  a_boot_only: assert property (
    $changed({ACTIVE_STATION, LINE_FRAMING}) |-> $past(SRST) ||
    $past(SRST, 2)) else $error("address or framing changed live");
  a_station_legal: assert property (
    !$past(SRST) && !$past(SRST, 2) |-> ACTIVE_STATION inside {[1:247]})
    else $error("station out of range");
  a_restart_pulse: assert property (
    clr_wr |-> ##[1:3] RESTART) else $error("no restart pulse");
  a_derate_clear: assert property (
    (TEMPERATURE < TEMP_CLEAR) [*3] |-> !DERATE)
    else $error("derate held when cool");
  a_protect_stop: assert property (
    PROTECTOR_OPEN [*3] |-> !RUN_ENABLE) else $error("runs with trip");
  // Main scenarios reached
  c_bad_func: cover property (mine && odd_fc);
  c_bcast: cover property (REQ_VALID && REQ_STATION == BROADCAST_ADDR);
  c_restart: cover property (RESTART);
endmodule

bind mfd_regif mfd_regif_asserts u_chk (.*);

// ==== sim/mfd_master_model.sv ====
module mfd_master_model (
  input wire logic CLK,
  input wire logic RSP_VALID,
  input wire logic RSP_EXCEPTION,
  input wire logic [7:0] RSP_FUNC,
  input wire logic [15:0] RSP_DATA,
  output logic REQ_VALID,
  output logic REQ_CRC_OK,
  output logic [7:0] REQ_STATION,
  output logic [7:0] REQ_FUNC,
  output logic [15:0] REQ_ADDR,
  output logic [15:0] REQ_DATA
);
  timeunit 1ns;
  timeprecision 1ns;
  // Idle bus at time zero
  initial begin
    REQ_VALID = 1'b0;
    {REQ_CRC_OK, REQ_STATION, REQ_FUNC, REQ_ADDR, REQ_DATA} = '0;
  end
  task automatic send(input logic [7:0] st, fc, input logic [15:0] a, d,
    input logic crc, output logic v, ex, output logic [7:0] f,
    output logic [15:0] r);
    @(negedge CLK);
    {REQ_CRC_OK, REQ_STATION, REQ_FUNC, REQ_ADDR, REQ_DATA} =
      {crc, st, fc, a, d};
    REQ_VALID = 1'b1;
    @(negedge CLK);
    REQ_VALID = 1'b0;
    // Stale fields inverted so nothing leans on them
    {REQ_CRC_OK, REQ_STATION, REQ_FUNC, REQ_ADDR, REQ_DATA} =
      ~{crc, st, fc, a, d};
    // Answer stands for one cycle after the second edge
    @(negedge CLK);
    {v, ex, f, r} = {RSP_VALID, RSP_EXCEPTION, RSP_FUNC, RSP_DATA};
  endtask
endmodule

// ==== sim/mfd_regif_tb_top.sv ====
module mfd_regif_tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  import mfd_pkg::*;
  typedef struct {
    logic [7:0] fc;
    logic [15:0] a, d, x;
    logic ex;
  } mfd_row_s;
  logic CLK = 1'b0;
  logic SRST = 1'b1;
  logic SERVICE_LINK = 1'b0;
  logic PROTECTOR_OPEN = 1'b0;
  logic TACHO_IN = 1'b0;
  logic [15:0] TEMPERATURE = 16'h28;
  logic [15:0] SPEED_NOW = 16'h0; // fan at rest while writing
  logic REQ_VALID, REQ_CRC_OK, RSP_VALID, RSP_EXCEPTION, RESTART;
  logic RUN_ENABLE, DERATE, SWITCH_HIGH, DIGITAL_OUT, v, e;
  logic [7:0] REQ_STATION, REQ_FUNC, RSP_FUNC, ACTIVE_STATION, f;
  logic [15:0] REQ_ADDR, REQ_DATA, RSP_DATA, VOLATILE_SETPOINT, r;
  logic [15:0] CURRENT_LIMIT;
  logic [1:0] LINE_RATE, LINE_FRAMING;
  logic [3:0] OP_MODE;
  int n_fail = 0;
  int n_tests = 0;
  int cyc = 0;
  logic [15:0] tv [3] = '{16'h5a, 16'h50, 16'h4a};
  // Function, address, data, expected data, exception
  mfd_row_s rows [18] = '{
    '{8'h06, 16'h2d, 16'h01, 16'h2d, 1'b0},
    '{8'h06, 16'h2d, 16'h00, 16'h03, 1'b1},
    '{8'h06, 16'h2d, 16'hf8, 16'h03, 1'b1},
    '{8'h03, 16'h2d, 16'h00, 16'h01, 1'b0},
    '{8'h06, 16'h30, 16'h03, 16'h03, 1'b1},
    '{8'h06, 16'h30, 16'h02, 16'h30, 1'b0},
    '{8'h06, 16'h22, 16'h0d, 16'h03, 1'b1},
    '{8'h06, 16'h22, 16'h0c, 16'h22, 1'b0},
    '{8'h03, 16'h22, 16'h00, 16'h0c, 1'b0},
    '{8'h06, 16'h2f, 16'h02, 16'h03, 1'b1},
    '{8'h06, 16'h2f, 16'h01, 16'h2f, 1'b0},
    '{8'h10, 16'h00, 16'h00, 16'h01, 1'b1},
    '{8'h04, 16'h0f, 16'h00, 16'h28, 1'b0},
    '{8'h06, 16'h42, 16'h1388, 16'h42, 1'b0},
    '{8'h03, 16'h42, 16'h00, 16'h00, 1'b0},
    '{8'h06, 16'h03, 16'h05, 16'h03, 1'b1},
    '{8'h06, 16'h2e, 16'h00, 16'h2e, 1'b0},
    '{8'h06, 16'h22, 16'h03, 16'h22, 1'b0} // follower mode
  };
  mfd_regif #(.VAR_SWITCH(1'b1), .SECOND(10)) dut (.*);
  mfd_master_model mst (.*);
  // Clock and hang guard
  always #20 CLK = ~CLK;
  always @(posedge CLK) begin
    cyc++;
    if (cyc == 3000) begin
      n_fail++;
      end_sim();
    end
  end
  // Compare and count
  task automatic chk(input string nm, input logic [15:0] s, x);
    n_tests++;
    if (s !== x) begin
      n_fail++;
      $display("CHECK FAILED %s expected %h seen %h", nm, x, s);
    end
  endtask
  // One frame to this station
  task automatic xf(input logic [7:0] fc, input logic [15:0] a, d);
    mst.send(8'h01, fc, a, d, 1'b1, v, e, f, r);
  endtask
  task automatic wt();
    repeat (3) @(negedge CLK);
  endtask
  task automatic end_sim();
    $display("tests %0d failures %0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  // Main sequence
  initial begin
    repeat (20) @(negedge CLK);
    SRST = 1'b0;
    repeat (2) @(negedge CLK);
    chk("station", ACTIVE_STATION, ADDR_RESET);
    chk("rate", LINE_RATE, RATE_9600);
    chk("framing", LINE_FRAMING, 16'h0);
    chk("mode", OP_MODE, MODE_RESET);
    chk("sw_low_speed", SWITCH_HIGH, 16'h1);
    $display("reset test done");
    foreach (rows[i]) begin
      xf(rows[i].fc, rows[i].a, rows[i].d);
      chk("rsp_valid", v, 16'h1);
      chk("rsp_exc", e, rows[i].ex);
      chk("rsp_func", f, rows[i].fc | {rows[i].ex, 7'h0});
      chk("rsp_data", r, rows[i].x);
    end
    chk("rate_now", LINE_RATE, 16'h1);
    chk("framing_boot", LINE_FRAMING, 16'h0);
    chk("vol_sp", VOLATILE_SETPOINT, 16'h1388);
    chk("mode_follow", OP_MODE, MODE_FOLLOW);
    $display("row test done");
    mst.send(BROADCAST_ADDR, 8'h06, HR_LINE_RATE, 16'h0, 1'b1, v, e, f, r);
    chk("bc_silent", v, 16'h0);
    chk("bc_rate", LINE_RATE, 16'h0);
    for (int k = 0; k < 2; k++) begin
      mst.send(k ? 8'h01 : 8'h05, 8'h06, HR_LINE_RATE, 16'h1, k == 0,
        v, e, f, r);
      chk("drop_silent", v, 16'h0);
      chk("drop_rate", LINE_RATE, 16'h0);
    end
    $display("discard test done");
    @(negedge CLK) SERVICE_LINK = 1'b1;
    xf(8'h06, HR_LINE_RATE, 16'h3);
    chk("svc_exc", e, 16'h0);
    chk("svc_rate", LINE_RATE, RATE_57600);
    @(negedge CLK) SERVICE_LINK = 1'b0;
    $display("service test done");
    @(negedge CLK) SRST = 1'b1;
    repeat (3) @(negedge CLK);
    SRST = 1'b0;
    repeat (2) @(negedge CLK);
    chk("boot_framing", LINE_FRAMING, 16'h2);
    chk("boot_station", ACTIVE_STATION, ADDR_RESET);
    chk("boot_rate", LINE_RATE, RATE_9600);
    $display("restart test done");
    xf(8'h06, HR_LINK_TIMEOUT, 16'h1);
    repeat (30) @(negedge CLK);
    chk("to_stop", RUN_ENABLE, 16'h0);
    xf(8'h04, IR_ALARM, 16'h0);
    chk("to_alarm", r, ALARM_LINK_LOST);
    xf(8'h06, HR_FAULT_CLEAR, 16'h1);
    xf(8'h04, IR_ALARM, 16'h0);
    chk("alarm_clr", r, 16'h0);
    xf(8'h03, HR_FAULT_CLEAR, 16'h0);
    chk("reset_self", r, 16'h0);
    xf(8'h06, HR_LINK_TIMEOUT, 16'h0);
    repeat (30) @(negedge CLK);
    xf(8'h04, IR_ALARM, 16'h0);
    chk("to_off", r, 16'h0);
    $display("timeout test done");
    foreach (tv[k]) begin
      @(negedge CLK) TEMPERATURE = tv[k];
      wt();
      chk("derate", DERATE, k < 2);
      chk("cur_limit", CURRENT_LIMIT, k < 2 ? 16'h7fff : 16'hffff);
    end
    @(negedge CLK) SPEED_NOW = 16'h7d0;
    wt();
    chk("sw_high_speed", SWITCH_HIGH, 16'h0);
    for (int k = 0; k < 2; k++) begin
      @(negedge CLK) TACHO_IN = ~TACHO_IN;
      wt();
      chk("tacho_out", DIGITAL_OUT, TACHO_IN);
    end
    @(negedge CLK) PROTECTOR_OPEN = 1'b1;
    wt();
    chk("trip_stop", RUN_ENABLE, 16'h0);
    xf(8'h04, IR_ALARM, 16'h0);
    chk("trip_flag", r, 16'h4);
    $display("thermal test done");
    end_sim();
  end
endmodule
